//--- hdl/tlu_line_alarm.sv
// Line interface alarm and control logic: loss of signal, short/open latching, driver gating.
// Assumes analog front end gives per-interval strobes and comparator levels from outside.
`timescale 1ns/1ns
`include "tlu_regs.svh"

// Functional notes
// - T1 mode declares loss after 192 intervals without a qualifying pulse.
// - Loss sets live loss status and sticky loss status.
// - Sticky loss raises interrupt only when its enable bit is set.
// - T1 clears after 24 pulses in 192 bits, no 100-zero run.
// - European modes, standard bit 0: declare after 255 empty intervals.
// - Standard bit 0: clear at 32 pulses within 255 intervals.
// - European modes, standard bit 1: declare after 2048 empty intervals.
// - Standard bit 1: clear on one pulse within 255 intervals.
// - 6312 kHz mode declares loss after 32 us below threshold.
// - Receiver power-down forces all receiver digital outputs low; code holds receive data and live loss low, but sticky loss still sets.
// - Line driver enabled only with hi-z pin low and enable bit set.
// - Alarm-force sends unframed all ones timed by master clock.
// - Short live flag; sticky on rise, sticky cleared on fall.
// - Each short/open sticky bit interrupts only when its enable set.
// - Short detection inactive for build-out codes 101, 110, 111.
// - Open live flag; sticky on rise, sticky cleared on fall.
// - Open detection inactive for build-out codes 101, 110, 111.
// - Waveform type from transmit mode field plus build-out field.
// - Recovery reference runs at the master tick rate, one period per master tick.
module tlu_line_alarm #(
    parameter int CNT_W = 12,
    parameter int LOW_LEVEL_CYC = `TLU_LOW_LEVEL_CYC
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Configuration
    input wire logic [1:0] i_rx_mode,
    input wire logic i_loss_standard_sel,
    input wire logic i_rx_powerdown,
    input wire logic i_tx_driver_on,
    input wire logic i_tx_all_ones_force,
    input wire logic [2:0] i_build_out_select,
    input wire logic [1:0] i_tx_waveform_type,
    input wire logic [`TLU_STAT_W-1:0] i_line_irq_enable,
    input wire logic [`TLU_STAT_W-1:0] i_status_clear,
    // Pins and front end (asynchronous)
    input wire logic i_tx_hiz_pin,
    input wire logic i_fe_interval,
    input wire logic i_fe_pulse_decl,
    input wire logic i_fe_pulse_clr,
    input wire logic i_fe_low_level,
    input wire logic i_fe_short,
    input wire logic i_fe_open,
    input wire logic i_rx_data,
    // Transmit data path from framer, same clock
    input wire logic i_tx_data,
    input wire logic i_tx_data_tick,
    input wire logic i_master_tick,
    // Outputs
    output logic [`TLU_STAT_W-1:0] o_line_live_status,
    output logic [`TLU_STAT_W-1:0] o_line_latched_status,
    output logic o_irq_out,
    output logic o_rx_data,
    output logic o_rx_los,
    output logic o_tx_data,
    output logic o_tx_line_oe,
    output logic [4:0] o_tx_wave_sel,
    output logic o_cdr_ref_x16
);
    initial begin
        if (CNT_W < 12 || LOW_LEVEL_CYC < 1 || LOW_LEVEL_CYC >= (1 << 16)) begin
            $error("tlu_line_alarm: unsupported parameters");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic intv_d;
        tlu_pkg::tlu_los_state_t los_st;
        logic [CNT_W-1:0] empty_cnt;
        logic [CNT_W-1:0] win_cnt;
        logic [CNT_W-1:0] pulse_cnt;
        logic [CNT_W-1:0] zero_run;
        logic run_bad;
        logic [15:0] low_cnt;
        logic los_sticky;
        logic irq;
        logic rx_data;
        logic tx_data;
        logic tx_oe;
        logic [4:0] wave;
        logic [3:0] cdr_div;
        logic cdr_ref;
    } tlu_st_t;

    tlu_st_t st;
    tlu_st_t next_st;

    logic [7:0] raw_in;
    logic intv;
    logic p_decl;
    logic p_clr;
    logic low_lvl;
    logic sc_raw;
    logic oc_raw;
    logic csu;
    logic sc_live;
    logic sc_rise;
    logic sc_fall;
    logic oc_live;
    logic oc_rise;
    logic oc_fall;
    logic [`TLU_STAT_W-1:0] latched;
    logic [`TLU_STAT_W-1:0] live;
    logic [CNT_W-1:0] decl_win;
    logic [CNT_W-1:0] clr_win;
    logic [CNT_W-1:0] clr_need;
    logic is_t1;
    logic is_6312;
    logic interval;
    logic hiz_s1;
    logic i_tx_hiz_pin_s;

    // Pin inputs gathered for the two-stage synchroniser
    assign raw_in = {1'b0, i_rx_data, i_fe_open, i_fe_short, i_fe_low_level,
        i_fe_pulse_clr, i_fe_pulse_decl, i_fe_interval};
    assign intv = st.sync2[0];
    assign p_decl = st.sync2[1];
    assign p_clr = st.sync2[2];
    assign low_lvl = st.sync2[3];
    // Long-haul codes switch off short/open detection
    assign csu = (i_build_out_select == `TLU_LBO_CSU_A) ||
        (i_build_out_select == `TLU_LBO_CSU_B) ||
        (i_build_out_select == `TLU_LBO_CSU_C);
    assign sc_raw = st.sync2[4] && !csu;
    assign oc_raw = st.sync2[5] && !csu;
    // One strobe per bit interval on the rising edge of the front-end tick
    assign interval = intv && !st.intv_d;

    ////////////////////////////////////////////////////////////////////////////
    // Short and open transition latches
    tlu_edge_latch u_short (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_live(sc_raw),
        .i_clr_rise(i_status_clear[`TLU_BIT_SC]),
        .i_clr_fall(i_status_clear[`TLU_BIT_SCC]),
        .o_live(sc_live),
        .o_rise(sc_rise),
        .o_fall(sc_fall)
    );

    tlu_edge_latch u_open (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_live(oc_raw),
        .i_clr_rise(i_status_clear[`TLU_BIT_OC]),
        .i_clr_fall(i_status_clear[`TLU_BIT_OCC]),
        .o_live(oc_live),
        .o_rise(oc_rise),
        .o_fall(oc_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Window limits per mode
    always_comb begin
        is_t1 = (i_rx_mode == 2'(tlu_pkg::TLU_MODE_T1));
        is_6312 = (i_rx_mode == 2'(tlu_pkg::TLU_MODE_6312));
        if (is_t1) begin
            decl_win = `TLU_T1_DECL_WIN;
            clr_win = `TLU_T1_DECL_WIN;
            clr_need = `TLU_T1_CLR_PULSES;
        end else if (!i_loss_standard_sel) begin
            decl_win = `TLU_EU_DECL_WIN;
            clr_win = `TLU_EU_CLR_WIN;
            clr_need = `TLU_EU_CLR_PULSES;
        end else begin
            decl_win = `TLU_ETSI_DECL_WIN;
            clr_win = `TLU_EU_CLR_WIN;
            clr_need = `TLU_ETSI_CLR_PULSES;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.sync1 = raw_in;
        next_st.sync2 = st.sync1;
        next_st.intv_d = intv;

        // Loss-of-signal detection
        if (is_6312) begin
            next_st.empty_cnt = '0;
            next_st.win_cnt = '0;
            next_st.pulse_cnt = '0;
            next_st.zero_run = '0;
            next_st.run_bad = 1'b0;
            if (low_lvl) begin
                if (st.low_cnt != 16'(LOW_LEVEL_CYC)) begin
                    next_st.low_cnt = st.low_cnt + 16'h0001;
                end
            end else begin
                next_st.low_cnt = '0;
            end
            if (low_lvl && st.low_cnt == 16'(LOW_LEVEL_CYC - 1)) begin
                next_st.los_st = tlu_pkg::TLU_LOS_LOST;
            end else if (!low_lvl) begin
                next_st.los_st = tlu_pkg::TLU_LOS_OK;
            end
        end else if (interval) begin
            next_st.low_cnt = '0;
            case (st.los_st)
                tlu_pkg::TLU_LOS_OK: begin
                    if (p_decl) begin
                        next_st.empty_cnt = '0;
                    end else if (st.empty_cnt + 1'b1 >= decl_win) begin
                        next_st.los_st = tlu_pkg::TLU_LOS_LOST;
                        next_st.empty_cnt = '0;
                        next_st.win_cnt = '0;
                        next_st.pulse_cnt = '0;
                        next_st.zero_run = '0;
                        next_st.run_bad = 1'b0;
                    end else begin
                        next_st.empty_cnt = st.empty_cnt + 1'b1;
                    end
                end
                tlu_pkg::TLU_LOS_LOST: begin
                    // Clear window counting qualified pulses
                    next_st.pulse_cnt = st.pulse_cnt + CNT_W'(p_clr);
                    next_st.zero_run = p_clr ? '0 : st.zero_run + 1'b1;
                    if (!p_clr && st.zero_run + 1'b1 >= `TLU_T1_ZERO_RUN && is_t1) begin
                        next_st.run_bad = 1'b1;
                    end
                    if (st.win_cnt + 1'b1 >= clr_win) begin
                        if (next_st.pulse_cnt >= clr_need && !next_st.run_bad) begin
                            next_st.los_st = tlu_pkg::TLU_LOS_OK;
                        end
                        next_st.win_cnt = '0;
                        next_st.pulse_cnt = '0;
                        next_st.run_bad = 1'b0;
                    end else begin
                        next_st.win_cnt = st.win_cnt + 1'b1;
                    end
                end
                default: begin
                    next_st.los_st = tlu_pkg::TLU_LOS_OK;
                end
            endcase
        end

        // Sticky loss: set wins over clear
        if (i_status_clear[`TLU_BIT_LOS]) begin
            next_st.los_sticky = 1'b0;
        end
        if (next_st.los_st == tlu_pkg::TLU_LOS_LOST && st.los_st != tlu_pkg::TLU_LOS_LOST) begin
            next_st.los_sticky = 1'b1;
        end

        // Interrupt from enabled sticky bits
        next_st.irq = |(latched & i_line_irq_enable);

        // Receiver outputs held low while powered down
        next_st.rx_data = i_rx_powerdown ? 1'b0 : st.sync2[6];

        // Transmit data: all ones on master timing, else framer data
        if (i_tx_all_ones_force) begin
            if (i_master_tick) begin
                next_st.tx_data = 1'b1;
            end
        end else if (i_tx_data_tick) begin
            next_st.tx_data = i_tx_data;
        end

        next_st.tx_oe = !st.sync2[7] && !i_tx_hiz_pin_s && i_tx_driver_on;
        next_st.wave = {i_tx_waveform_type, i_build_out_select};

        // Recovery reference at master tick rate, high for the first 8 clocks after each tick
        next_st.cdr_div = st.cdr_div + 4'h1;
        if (i_master_tick) begin
            next_st.cdr_div = '0;
        end
        next_st.cdr_ref = (st.cdr_div < 4'(`TLU_CDR_MULT / 2));
    end

    // Hi-z pin passes its own two flip-flops
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hiz_s1 <= 1'b1;
            i_tx_hiz_pin_s <= 1'b1;
        end else if (i_ce) begin
            hiz_s1 <= i_tx_hiz_pin;
            i_tx_hiz_pin_s <= hiz_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
            st.los_st <= tlu_pkg::TLU_LOS_OK;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    // Status vectors; live loss forced low in power-down
    always_comb begin
        live = '0;
        live[`TLU_BIT_LOS] = (st.los_st == tlu_pkg::TLU_LOS_LOST) && !i_rx_powerdown;
        live[`TLU_BIT_SC] = sc_live;
        live[`TLU_BIT_OC] = oc_live;
        latched = '0;
        latched[`TLU_BIT_LOS] = st.los_sticky;
        latched[`TLU_BIT_SC] = sc_rise;
        latched[`TLU_BIT_SCC] = sc_fall;
        latched[`TLU_BIT_OC] = oc_rise;
        latched[`TLU_BIT_OCC] = oc_fall;
    end

    assign o_line_live_status = live;
    assign o_line_latched_status = latched;
    assign o_irq_out = st.irq;
    assign o_rx_data = st.rx_data;
    assign o_rx_los = live[`TLU_BIT_LOS];
    assign o_tx_data = st.tx_data;
    assign o_tx_line_oe = st.tx_oe;
    assign o_tx_wave_sel = st.wave;
    assign o_cdr_ref_x16 = st.cdr_ref;
endmodule

//--- hdl/tlu_regs.svh
// Constants for the timing line alarm logic: field positions, reset values, timing counts.
// Assumes inclusion by bare name from the design module and the checker.
`ifndef TLU_REGS_SVH
`define TLU_REGS_SVH

// Loss-of-signal windows, in pulse intervals
`define TLU_T1_DECL_WIN 12'd192
`define TLU_T1_CLR_PULSES 12'd24
`define TLU_T1_ZERO_RUN 12'd100
`define TLU_EU_DECL_WIN 12'd255
`define TLU_EU_CLR_WIN 12'd255
`define TLU_EU_CLR_PULSES 12'd32
`define TLU_ETSI_DECL_WIN 12'd2048
`define TLU_ETSI_CLR_PULSES 12'd1

// 6312 kHz mode: low level time and clock period, both in ns
`define TLU_LOW_LEVEL_NS 32000
`define TLU_CLK_PERIOD_NS 100
`define TLU_LOW_LEVEL_CYC ((`TLU_LOW_LEVEL_NS + `TLU_CLK_PERIOD_NS - 1) / `TLU_CLK_PERIOD_NS)

// Recovery reference multiplier
`define TLU_CDR_MULT 16

// Status and enable bit positions
`define TLU_BIT_LOS 0
`define TLU_BIT_SC 1
`define TLU_BIT_SCC 2
`define TLU_BIT_OC 3
`define TLU_BIT_OCC 4
`define TLU_STAT_W 5
`define TLU_STAT_RST 5'h00

// Long-haul build-out codes
`define TLU_LBO_CSU_A 3'h5
`define TLU_LBO_CSU_B 3'h6
`define TLU_LBO_CSU_C 3'h7

`endif

//--- hdl/tlu_pkg.sv
// Types for the timing line alarm logic.
// Assumes tlu_regs.svh is available on the include path.
package tlu_pkg;
    // Receive line modes
    typedef enum logic [1:0] {
        TLU_MODE_T1 = 2'h0,
        TLU_MODE_EU = 2'h1,
        TLU_MODE_2048 = 2'h2,
        TLU_MODE_6312 = 2'h3
    } tlu_mode_t;

    // Loss-of-signal states, one-hot
    typedef enum logic [1:0] {
        TLU_LOS_OK = 2'h1,
        TLU_LOS_LOST = 2'h2
    } tlu_los_state_t;
endpackage

//--- hdl/tlu_edge_latch.sv
// Live-indication edge latch: rise and fall set sticky bits.
// Assumes a synchronous live input and a write-one-to-clear strobe on the same clock.
`timescale 1ns/1ns
module tlu_edge_latch (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_live,
    input wire logic i_clr_rise,
    input wire logic i_clr_fall,
    output logic o_live,
    output logic o_rise,
    output logic o_fall
);
    typedef struct packed {
        logic live;
        logic rise;
        logic fall;
    } tlu_edge_st_t;

    tlu_edge_st_t st;
    tlu_edge_st_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // Sticky set wins over clear
    always_comb begin
        next_st = st;
        next_st.live = i_live;
        if (i_clr_rise) begin
            next_st.rise = 1'b0;
        end
        if (i_clr_fall) begin
            next_st.fall = 1'b0;
        end
        if (i_live && !st.live) begin
            next_st.rise = 1'b1;
        end
        if (!i_live && st.live) begin
            next_st.fall = 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_live = st.live;
    assign o_rise = st.rise;
    assign o_fall = st.fall;
endmodule

//--- dv/tlu_fe_model.sv
// Front end model: one interval strobe per request, qualified pulses, levels, receive data.
// Assumes the bench requests one interval at a time, never on two edges in a row.
`timescale 1ns/1ns
module tlu_fe_model (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_fire,
    input wire logic i_pulse,
    input wire logic i_low,
    input wire logic i_short,
    input wire logic i_open,
    output logic o_interval,
    output logic o_pulse_decl,
    output logic o_pulse_clr,
    output logic o_low,
    output logic o_short,
    output logic o_open,
    output logic o_rx_data
);
    // Strobe high one cycle per request, pulse qualified only inside it
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            {o_interval, o_pulse_decl, o_pulse_clr, o_low, o_short, o_open, o_rx_data} <= '0;
        end else begin
            o_interval <= i_fire;
            o_pulse_decl <= i_fire && i_pulse;
            o_pulse_clr <= i_fire && i_pulse;
            o_low <= i_low;
            o_short <= i_short;
            o_open <= i_open;
            o_rx_data <= ~o_rx_data; // Toggles so a stale value never looks valid
        end
    end
endmodule

//--- dv/tlu_line_alarm_props.sv
// Checker for the line alarm block: status, interrupt, gating and build-out relations.
// Assumes binding into tlu_line_alarm with its clock enable held high.
`timescale 1ns/1ns
`include "tlu_regs.svh"
module tlu_line_alarm_props (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_rx_powerdown,
    input wire logic i_tx_driver_on,
    input wire logic i_tx_hiz_pin,
    input wire logic [2:0] i_build_out_select,
    input wire logic [1:0] i_tx_waveform_type,
    input wire logic [`TLU_STAT_W-1:0] i_line_irq_enable,
    input wire logic [`TLU_STAT_W-1:0] o_line_live_status,
    input wire logic [`TLU_STAT_W-1:0] o_line_latched_status,
    input wire logic o_irq_out,
    input wire logic o_rx_data,
    input wire logic o_rx_los,
    input wire logic o_tx_line_oe,
    input wire logic [4:0] o_tx_wave_sel
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Any enabled sticky bit, and long-haul build-out
    wire pend = |(o_line_latched_status & i_line_irq_enable);
    wire csu = i_build_out_select >= 3'h5;
    ////////////////////////////////////////////////////////////////////////////////
    property p_irq_on; pend [*2] |-> o_irq_out; endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq low with enabled sticky");
    property p_irq_off; !pend [*2] |-> !o_irq_out; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq high with none enabled");
    property p_los_stk;
        $rose(o_line_live_status[0]) && !i_rx_powerdown && !$past(i_rx_powerdown)
            |-> ##[0:1] o_line_latched_status[0];
    endproperty
    a_los_stk: assert property (p_los_stk) else $error("loss sticky not set");
    property p_pd; i_rx_powerdown [*2] |-> !(o_rx_data || o_rx_los || o_line_live_status[0]);
    endproperty
    a_pd: assert property (p_pd) else $error("receiver output high in power-down");
    property p_oe_off; (i_tx_hiz_pin || !i_tx_driver_on) [*4] |-> !o_tx_line_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("driver enabled while off");
    property p_oe_on; (!i_tx_hiz_pin && i_tx_driver_on) [*4] |-> o_tx_line_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("driver not enabled");
    property p_sc_csu; csu [*4] |-> !o_line_live_status[1]; endproperty
    a_sc_csu: assert property (p_sc_csu) else $error("short live in long-haul code");
    property p_oc_csu; csu [*4] |-> !o_line_live_status[3]; endproperty
    a_oc_csu: assert property (p_oc_csu) else $error("open live in long-haul code");
    property p_sc_rise; $rose(o_line_live_status[1]) |-> ##[0:1] o_line_latched_status[1];
    endproperty
    a_sc_rise: assert property (p_sc_rise) else $error("short sticky not set");
    property p_oc_fall; $fell(o_line_live_status[3]) |-> ##[0:1] o_line_latched_status[4];
    endproperty
    a_oc_fall: assert property (p_oc_fall) else $error("open cleared sticky not set");
    property p_wave;
        $stable({i_tx_waveform_type, i_build_out_select}) [*2]
            |-> o_tx_wave_sel == {i_tx_waveform_type, i_build_out_select};
    endproperty
    a_wave: assert property (p_wave) else $error("waveform select mismatch");
    ////////////////////////////////////////////////////////////////////////////////
    c_irq: cover property (o_irq_out);
    c_occ: cover property (o_line_latched_status[4]);
    c_los: cover property ($rose(o_line_live_status[0]));
endmodule
bind tlu_line_alarm tlu_line_alarm_props tlu_line_alarm_props_i (.i_clk, .i_rstn,
    .i_rx_powerdown, .i_tx_driver_on, .i_tx_hiz_pin, .i_build_out_select, .i_tx_waveform_type,
    .i_line_irq_enable, .o_line_live_status, .o_line_latched_status, .o_irq_out, .o_rx_data,
    .o_rx_los, .o_tx_line_oe, .o_tx_wave_sel);

//--- dv/tlu_line_alarm_test.sv
// Self-checking bench for the line alarm block, with the front end model beside it.
// Assumes a 10 MHz clock; the low level time is shortened to 8 cycles.
`timescale 1ns/1ns
module tlu_line_alarm_test;
    logic i_clk, i_rstn, i_rx_powerdown, i_tx_driver_on, i_tx_all_ones_force;
    logic i_loss_standard_sel, i_tx_hiz_pin, i_tx_data, fire, pulse, low, shrt, opn, tick_en;
    logic [1:0] i_rx_mode, i_tx_waveform_type;
    logic [2:0] i_build_out_select;
    logic [4:0] i_line_irq_enable, i_status_clear, o_line_live_status, o_line_latched_status;
    logic [4:0] o_tx_wave_sel;
    logic i_fe_interval, i_fe_pulse_decl, i_fe_pulse_clr, i_fe_low_level, i_fe_short, i_fe_open;
    logic i_rx_data, o_irq_out, o_rx_data, o_rx_los, o_tx_data, o_tx_line_oe, o_cdr_ref_x16, prev;
    logic i_master_tick = 1'b0;
    logic i_tx_data_tick = 1'b0;
    int err_count, cmp_count, n, rises;
    int seed = 89;
    ////////////////////////////////////////////////////////////////////////////////
    tlu_line_alarm #(.LOW_LEVEL_CYC(8)) tlu_line_alarm_i (.i_clk, .i_rstn, .i_ce(1'b1),
        .i_rx_mode, .i_loss_standard_sel, .i_rx_powerdown, .i_tx_driver_on, .i_tx_all_ones_force,
        .i_build_out_select, .i_tx_waveform_type, .i_line_irq_enable, .i_status_clear,
        .i_tx_hiz_pin, .i_fe_interval, .i_fe_pulse_decl, .i_fe_pulse_clr, .i_fe_low_level,
        .i_fe_short, .i_fe_open, .i_rx_data, .i_tx_data, .i_tx_data_tick, .i_master_tick,
        .o_line_live_status, .o_line_latched_status, .o_irq_out, .o_rx_data, .o_rx_los,
        .o_tx_data, .o_tx_line_oe, .o_tx_wave_sel, .o_cdr_ref_x16);
    tlu_fe_model tlu_fe_model_i (.i_clk, .i_rstn, .i_fire(fire), .i_pulse(pulse), .i_low(low),
        .i_short(shrt), .i_open(opn), .o_interval(i_fe_interval), .o_pulse_decl(i_fe_pulse_decl),
        .o_pulse_clr(i_fe_pulse_clr), .o_low(i_fe_low_level), .o_short(i_fe_short),
        .o_open(i_fe_open), .o_rx_data(i_rx_data));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and free-running ticks
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        // Master tick once every 16 cycles so the recovery reference has a full period
        i_master_tick <= (($time / 100) % 16) == 15;
        i_tx_data_tick <= tick_en & 1'($random(seed));
    end
    // Expectations
    function automatic logic exp_oe(input logic hiz, input logic on);
        return !hiz && on;
    endfunction
    function automatic logic csu(input int code);
        return (code % 8) >= 5;
    endfunction
    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk);
    endtask
    // Intervals two cycles apart, then time for the answer to land
    task automatic iv(input int k, input logic p);
        repeat (k) begin
            fire <= 1'b1;
            pulse <= p;
            @(posedge i_clk);
            fire <= 1'b0;
            @(posedge i_clk);
        end
        cyc(5);
    endtask
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic declare(input int k);
        iv(k - 1, 1'b0);
        chk(o_line_live_status[0], 1'b0);
        iv(1, 1'b0);
        chk(o_line_live_status[0], 1'b1);
    endtask
    task automatic clear(input logic [4:0] m);
        i_status_clear <= m;
        @(posedge i_clk);
        i_status_clear <= 5'h00;
        cyc(3);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #6000000;
        err_count++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {i_rstn, i_rx_powerdown, i_tx_driver_on, i_tx_all_ones_force, i_loss_standard_sel} <= '0;
        {i_rx_mode, i_tx_waveform_type, i_build_out_select, i_line_irq_enable} <= '0;
        {i_status_clear, i_tx_hiz_pin, i_tx_data, fire, pulse, low, shrt, opn, tick_en} <= '0;
        cyc(8);
        i_rstn <= 1'b1;
        i_line_irq_enable <= 5'h1F;
        declare(192);
        chk(o_line_latched_status, 5'h01);
        chk(o_irq_out, 1'b1);
        for (int k = 0; k < 400; k++) iv(1, k % 9 == 0);
        chk(o_line_live_status[0], 1'b1);
        iv(400, 1'b1);
        chk({o_irq_out, o_line_live_status[0]}, 5'h02);
        clear(5'h01);
        chk({o_irq_out, o_line_latched_status[0]}, 5'h00);
        i_line_irq_enable <= 5'h1E;
        iv(192, 1'b0);
        chk({o_irq_out, o_line_latched_status[0]}, 5'h01);
        i_rx_powerdown <= 1'b1;
        cyc(4);
        chk({o_rx_data, o_rx_los, o_line_live_status[0]}, 5'h00);
        i_rx_powerdown <= 1'b0;
        iv(400, 1'b1);
        clear(5'h01);
        i_line_irq_enable <= 5'h1F;
        for (int i = 0; i < 4; i++) begin
            i_rx_mode <= 2'(1 + i / 2);
            i_loss_standard_sel <= i[0];
            iv(4, 1'b1);
            declare(i[0] ? 2048 : 255);
            if (i[0]) begin
                iv(1, 1'b1);
                iv(260, 1'b0);
                chk(o_line_live_status[0], 1'b0);
            end else begin
                iv(31, 1'b1);
                iv(300, 1'b0);
                chk(o_line_live_status[0], 1'b1);
                iv(520, 1'b1);
                chk(o_line_live_status[0], 1'b0);
            end
        end
        i_rx_mode <= 2'h3;
        low <= 1'b1;
        cyc(3);
        low <= 1'b0;
        cyc(6);
        chk(o_line_live_status[0], 1'b0);
        low <= 1'b1;
        cyc(14);
        chk(o_line_live_status[0], 1'b1);
        low <= 1'b0;
        cyc(8);
        clear(5'h1F);
        for (int i = 0; i < 4; i++) begin
            i_tx_hiz_pin <= i[0];
            i_tx_driver_on <= i[1];
            cyc(5);
            chk(o_tx_line_oe, exp_oe(i[0], i[1]));
        end
        // Short then open, every build-out code, random interrupt enables
        for (int i = 0; i < 16; i++) begin
            i_build_out_select <= 3'(i);
            i_line_irq_enable <= 5'($random(seed)) & 5'h1E;
            n = 1 + 2 * (i / 8);
            cyc(4);
            {opn, shrt} <= (i < 8) ? 2'b01 : 2'b10;
            cyc(6);
            chk(o_line_latched_status[n], !csu(i));
            chk(o_irq_out, !csu(i) && i_line_irq_enable[n]);
            {opn, shrt} <= 2'b00;
            cyc(6);
            chk(o_line_latched_status[n + 1], !csu(i));
            clear(5'h1E);
        end
        tick_en <= 1'b1;
        repeat (20) begin
            {i_tx_waveform_type, i_build_out_select, i_tx_data} <= 6'($random(seed));
            cyc(3);
            chk(o_tx_wave_sel, {i_tx_waveform_type, i_build_out_select});
        end
        tick_en <= 1'b0;
        i_tx_data <= 1'b0;
        i_tx_all_ones_force <= 1'b1;
        cyc(8);
        chk(o_tx_data, 1'b1);
        prev = o_cdr_ref_x16;
        rises = 0;
        repeat (160) begin
            @(posedge i_clk);
            rises += (o_cdr_ref_x16 && !prev);
            prev = o_cdr_ref_x16;
        end
        chk(5'(rises), 5'h0A);
        conclude();
    end
endmodule
